/* File: src/aps_pkg.sv */
// package of constants and types for the amplifier protection supervisor
// assumes a 50 MHz pclk and comparator levels that are high while a fault
// is present
package aps_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ         = 50_000_000;
	localparam int MS_HZ          = 1_000;
	localparam int MS_CYCLES      = CLK_HZ / MS_HZ;
	localparam int SWITCH_HZ      = 335_000;
	// switching period rounds down so that no cycle is ever missed
	localparam int SWITCH_CYCLES  = CLK_HZ / SWITCH_HZ;
	localparam int RESTART_MS     = 100;
	localparam int STATUS_MS      = 100;

	// ----------------------------------------------------------------
	// temperature thresholds in degrees celsius
	// ----------------------------------------------------------------
	localparam logic [7:0] T_WARN_SET   = 8'd139;
	localparam logic [7:0] T_WARN_CLR   = 8'd138;
	localparam logic [7:0] T_FOLD_ACT   = 8'd145;
	localparam logic [7:0] T_FOLD_HALF  = 8'd153;
	localparam logic [7:0] T_PROT_ACT   = 8'd154;
	localparam logic [2:0] FOLD_MAX_DB  = 3'd6;

	// ----------------------------------------------------------------
	// mode level thresholds in tenths of a volt
	// ----------------------------------------------------------------
	localparam logic [6:0] MODE_MUTE_ON  = 7'd22;
	localparam logic [6:0] MODE_MUTE_OFF = 7'd8;
	localparam logic [6:0] MODE_OPERATE  = 7'd42;
	localparam logic [6:0] MODE_FOLD_MAX = 7'd55;
	localparam logic [6:0] MODE_NO_FOLD  = 7'd66;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_TEMP   = 8'h08;
	localparam int CTRL_HOLD_BIT      = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_STANDBY,
		MODE_MUTE,
		MODE_OPERATE_FOLD,
		MODE_OPERATE_NOFOLD
	} aps_mode_t;

	typedef enum logic [2:0] {
		ST_STANDBY,
		ST_WINDOW,
		ST_MUTE,
		ST_OPERATE,
		ST_SHUTDOWN
	} aps_state_t;

endpackage

/* File: src/aps_timer.sv */
// tick counter used for the restart delay and the status pulse stretch
// assumes tick is a one-cycle enable on the same clock
`timescale 1ns/100ps
`default_nettype none

module aps_timer #(
	parameter int TICKS = 100
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic tick,
	input  wire logic restart,
	output logic      done
);

	localparam int W = $clog2(TICKS + 1);
	localparam logic [W-1:0] LAST = W'(TICKS);

	logic [W-1:0] count;

	// restart wins over counting, so a fault seen mid-count starts over
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else if (restart) begin
			count <= '0;
		end else if (tick && count != LAST) begin
			count <= count + W'(1);
		end
	end

	assign done = (count == LAST);

endmodule

`default_nettype wire

/* File: src/aps_supervisor.sv */
// fault supervisor and restart sequencer for a stereo class-d amplifier
// assumes fault comparators, temperature and supply codes arrive
// asynchronously as levels; the two diagnostic pins are open-drain
`timescale 1ns/100ps
`default_nettype none

module aps_supervisor #(
	parameter int MS_CYCLES     = aps_pkg::MS_CYCLES,
	parameter int SWITCH_CYCLES = aps_pkg::SWITCH_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// analog comparator levels
	input  wire logic        output_short_supply,
	input  wire logic        undervoltage_fault,
	input  wire logic        overvoltage_fault,
	input  wire logic        clock_loss_fault,
	input  wire logic        overcurrent_fault,
	input  wire logic        current_limit_active,
	input  wire logic [7:0]  positive_analog_supply,
	input  wire logic [7:0]  negative_analog_supply,
	input  wire logic [7:0]  junction_temp,
	input  wire logic [6:0]  mode_level,
	// amplifier control
	output logic             power_stage_en,
	output logic             switching_en,
	output logic             mute_en,
	output logic      [2:0]  thermal_gain_foldback,
	// open-drain diagnostics, enable high pulls the pin low
	output logic             thermal_warning_out_o,
	output logic             thermal_warning_out_oe,
	output logic             protection_status_out_o,
	output logic             protection_status_out_oe
);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	localparam int NB = 6;
	localparam int NW = 8 + 8 + 8 + 7;

	logic [NB-1:0] bit_meta;
	logic [NB-1:0] bit_sync;
	logic [NW-1:0] word_meta;
	logic [NW-1:0] word_sync;

	// multi-bit codes come from slow analog paths; a torn sample lasts
	// one cycle and only nudges a threshold compare
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_meta  <= '0;
			bit_sync  <= '0;
			word_meta <= '0;
			word_sync <= '0;
		end else begin
			bit_meta  <= {output_short_supply, undervoltage_fault,
				overvoltage_fault, clock_loss_fault, overcurrent_fault,
				current_limit_active};
			bit_sync  <= bit_meta;
			word_meta <= {positive_analog_supply, negative_analog_supply,
				junction_temp, mode_level};
			word_sync <= word_meta;
		end
	end

	logic       short_s;
	logic       uv_s;
	logic       ov_s;
	logic       clk_loss_s;
	logic       oc_s;
	logic       limit_s;
	logic [7:0] vpos_s;
	logic [7:0] vneg_s;
	logic [7:0] temp_s;
	logic [6:0] mode_s;

	assign {short_s, uv_s, ov_s, clk_loss_s, oc_s, limit_s} = bit_sync;
	assign {vpos_s, vneg_s, temp_s, mode_s} = word_sync;

	// ----------------------------------------------------------------
	// rate dividers
	// ----------------------------------------------------------------
	logic [$clog2(MS_CYCLES)-1:0]     ms_cnt;
	logic [$clog2(SWITCH_CYCLES)-1:0] sw_cnt;
	logic                             ms_tick;
	logic                             sw_tick;

	// millisecond tick for the delays, switching tick for limit pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_cnt  <= '0;
			sw_cnt  <= '0;
			ms_tick <= 1'b0;
			sw_tick <= 1'b0;
		end else begin
			ms_tick <= (ms_cnt == $bits(ms_cnt)'(MS_CYCLES - 1));
			sw_tick <= (sw_cnt == $bits(sw_cnt)'(SWITCH_CYCLES - 1));
			if (ms_cnt == $bits(ms_cnt)'(MS_CYCLES - 1)) begin
				ms_cnt <= '0;
			end else begin
				ms_cnt <= ms_cnt + $bits(ms_cnt)'(1);
			end
			if (sw_cnt == $bits(sw_cnt)'(SWITCH_CYCLES - 1)) begin
				sw_cnt <= '0;
			end else begin
				sw_cnt <= sw_cnt + $bits(sw_cnt)'(1);
			end
		end
	end

	// ----------------------------------------------------------------
	// mode decode
	// ----------------------------------------------------------------
	aps_pkg::aps_mode_t mode;
	logic               fold_allowed;

	// standby/mute uses two thresholds; mute/operate are plain bands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode         <= aps_pkg::MODE_STANDBY;
			fold_allowed <= 1'b1;
		end else begin
			fold_allowed <= (mode_s <= aps_pkg::MODE_FOLD_MAX);
			if (mode_s >= aps_pkg::MODE_NO_FOLD) begin
				mode <= aps_pkg::MODE_OPERATE_NOFOLD;
			end else if (mode_s >= aps_pkg::MODE_OPERATE) begin
				mode <= aps_pkg::MODE_OPERATE_FOLD;
			end else if (mode_s >= aps_pkg::MODE_MUTE_ON) begin
				mode <= aps_pkg::MODE_MUTE;
			end else if (mode_s < aps_pkg::MODE_MUTE_OFF) begin
				mode <= aps_pkg::MODE_STANDBY;
			end else if (mode != aps_pkg::MODE_STANDBY) begin
				mode <= aps_pkg::MODE_MUTE;
			end
		end
	end

	// ----------------------------------------------------------------
	// thermal warning and foldback
	// ----------------------------------------------------------------
	logic       warn;
	logic [7:0] fold_delta;
	assign fold_delta = temp_s - aps_pkg::T_FOLD_ACT;

	// warning works in every mode, foldback only when allowed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			warn                  <= 1'b0;
			thermal_gain_foldback <= '0;
		end else begin
			if (temp_s >= aps_pkg::T_WARN_SET) begin
				warn <= 1'b1;
			end else if (temp_s < aps_pkg::T_WARN_CLR) begin
				warn <= 1'b0;
			end
			if (!fold_allowed || temp_s <= aps_pkg::T_FOLD_ACT) begin
				thermal_gain_foldback <= '0;
			end else if (temp_s >= aps_pkg::T_FOLD_HALF) begin
				thermal_gain_foldback <= aps_pkg::FOLD_MAX_DB;
			end else begin
				// three quarters of a dB per degree: 6 dB over 8 degrees
				thermal_gain_foldback <= 3'((fold_delta * 8'd3) >> 2);
			end
		end
	end

	// ----------------------------------------------------------------
	// shutdown fault levels
	// ----------------------------------------------------------------
	logic [8:0] vpos_x2;
	logic [8:0] vneg_x2;
	logic       unbalance;
	logic       overtemp;
	logic       level_fault;
	assign vpos_x2 = {vpos_s, 1'b0};
	assign vneg_x2 = {vneg_s, 1'b0};
	// magnitudes, so a ratio above two either way trips
	assign unbalance = ({1'b0, vpos_s} > vneg_x2) ||
		({1'b0, vneg_s} > vpos_x2);
	assign overtemp = (temp_s >= aps_pkg::T_PROT_ACT);
	// foldback and warning are deliberately absent here
	assign level_fault = overtemp | uv_s | ov_s | unbalance |
		clk_loss_s;

	// ----------------------------------------------------------------
	// apb control register
	// ----------------------------------------------------------------
	logic [31:0] ctrl;
	logic        bus_write;
	assign bus_write = psel && penable && pwrite && pready;

	// hold bit keeps the amplifier in standby under software control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= aps_pkg::CTRL_RESET;
		end else if (bus_write && paddr == aps_pkg::REG_CTRL) begin
			ctrl <= {31'h0000_0000, pwdata[aps_pkg::CTRL_HOLD_BIT]};
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	aps_pkg::aps_state_t state;
	logic                restart_done;
	logic                stretch_done;
	logic                stretch_start;
	logic                want_on;

	assign want_on = (mode != aps_pkg::MODE_STANDBY) &&
		!ctrl[aps_pkg::CTRL_HOLD_BIT];

	// the delay counter is held at zero while any level fault remains,
	// so the 100 ms runs from the last level fault to clear, or from shutdown entry after an overcurrent
	aps_timer #(
		.TICKS(aps_pkg::RESTART_MS)
	) u_restart (
		.pclk    (pclk),
		.presetn (presetn),
		.tick    (ms_tick),
		.restart (state != aps_pkg::ST_SHUTDOWN || level_fault),
		.done    (restart_done)
	);

	assign stretch_start = (state != aps_pkg::ST_SHUTDOWN &&
		state != aps_pkg::ST_WINDOW) && (level_fault || oc_s ||
		(state == aps_pkg::ST_STANDBY && want_on));

	// status pulse stretch, started on start-up and on any shutdown not entered from the short check
	aps_timer #(
		.TICKS(aps_pkg::STATUS_MS)
	) u_stretch (
		.pclk    (pclk),
		.presetn (presetn),
		.tick    (ms_tick),
		.restart (stretch_start),
		.done    (stretch_done)
	);

	// faults win over everything; overcurrent only arrives here once
	// the external low-impedance path has discharged its capacitor
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= aps_pkg::ST_STANDBY;
		end else if (level_fault || (oc_s &&
			power_stage_en)) begin
			state <= aps_pkg::ST_SHUTDOWN;
		end else begin
			case (state)
			aps_pkg::ST_STANDBY: begin
				if (want_on) begin
					state <= aps_pkg::ST_WINDOW;
				end
			end
			aps_pkg::ST_WINDOW: begin
				if (!want_on) begin
					state <= aps_pkg::ST_STANDBY;
				end else if (!short_s) begin
					state <= aps_pkg::ST_MUTE;
				end
			end
			aps_pkg::ST_MUTE: begin
				if (!want_on) begin
					state <= aps_pkg::ST_STANDBY;
				end else if (mode == aps_pkg::MODE_OPERATE_FOLD ||
					mode == aps_pkg::MODE_OPERATE_NOFOLD) begin
					state <= aps_pkg::ST_OPERATE;
				end
			end
			aps_pkg::ST_OPERATE: begin
				if (!want_on) begin
					state <= aps_pkg::ST_STANDBY;
				end else if (mode == aps_pkg::MODE_MUTE) begin
					state <= aps_pkg::ST_MUTE;
				end
			end
			aps_pkg::ST_SHUTDOWN: begin
				// every restart passes the short check again
				if (restart_done) begin
					state <= aps_pkg::ST_WINDOW;
				end
			end
			default: begin
				state <= aps_pkg::ST_STANDBY;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// amplifier control and diagnostic pins
	// ----------------------------------------------------------------
	// power stages stay off in standby, shutdown and the short check
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_stage_en           <= 1'b0;
			switching_en             <= 1'b0;
			mute_en                  <= 1'b1;
			thermal_warning_out_o    <= 1'b0;
			thermal_warning_out_oe   <= 1'b0;
			protection_status_out_o  <= 1'b0;
			protection_status_out_oe <= 1'b0;
		end else begin
			power_stage_en <= (state == aps_pkg::ST_MUTE ||
				state == aps_pkg::ST_OPERATE);
			switching_en   <= (state == aps_pkg::ST_MUTE ||
				state == aps_pkg::ST_OPERATE);
			mute_en        <= (state != aps_pkg::ST_OPERATE);
			thermal_warning_out_o  <= 1'b0;
			thermal_warning_out_oe <= warn;
			protection_status_out_o <= 1'b0;
			// steady during shutdown and short check, stretched after a start-up,
			// one pulse per switching period while only limiting
			protection_status_out_oe <= (state == aps_pkg::ST_SHUTDOWN) ||
				(state == aps_pkg::ST_WINDOW) ||
				!stretch_done ||
				(limit_s && sw_tick && switching_en);
		end
	end

	// ----------------------------------------------------------------
	// apb read path, one wait state
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (psel && penable && !pready) begin
			pready  <= 1'b1;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			case (paddr)
			aps_pkg::REG_CTRL: begin
				prdata <= pwrite ? 32'h0000_0000 : ctrl;
			end
			aps_pkg::REG_STATUS: begin
				prdata <= pwrite ? 32'h0000_0000 : {16'h0000,
					short_s, oc_s, clk_loss_s, unbalance, ov_s, uv_s,
					overtemp, warn, 3'h0, 2'(mode), 3'(state)};
			end
			aps_pkg::REG_TEMP: begin
				prdata <= pwrite ? 32'h0000_0000 : {21'h000000,
					thermal_gain_foldback, temp_s};
			end
			default: begin
				pslverr <= 1'b1;
			end
			endcase
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

endmodule

`default_nettype wire

/* File: tb/aps_props.sv */
// checker on the supervisor ports
// assumes MS_CYCLES equals the value of the bound instance
`timescale 1ns/100ps
`default_nettype none
module aps_props #(
	parameter int MS_CYCLES = 10
) (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       output_short_supply,
	input wire logic       undervoltage_fault,
	input wire logic       overvoltage_fault,
	input wire logic       clock_loss_fault,
	input wire logic       overcurrent_fault,
	input wire logic [7:0] positive_analog_supply,
	input wire logic [7:0] negative_analog_supply,
	input wire logic [7:0] junction_temp,
	input wire logic [6:0] mode_level,
	input wire logic       power_stage_en,
	input wire logic       switching_en,
	input wire logic       mute_en,
	input wire logic [2:0] thermal_gain_foldback,
	input wire logic       thermal_warning_out_o,
	input wire logic       thermal_warning_out_oe,
	input wire logic       protection_status_out_o,
	input wire logic       protection_status_out_oe
);
	// ------------------------------------
	// helpers
	// ------------------------------------
	// two ms of slack cover the free-running tick phase
	localparam int MIN_WAIT = 98 * MS_CYCLES;
	logic [8:0] pos2, neg2;
	logic       unbal, lvl, hot;
	int         quiet, run;
	assign pos2  = {positive_analog_supply, 1'b0};
	assign neg2  = {negative_analog_supply, 1'b0};
	assign unbal = {1'b0, positive_analog_supply} > neg2
		|| {1'b0, negative_analog_supply} > pos2;
	assign lvl = undervoltage_fault || overvoltage_fault
		|| clock_loss_fault || unbal || junction_temp >= 8'h9A;
	assign hot = lvl || (overcurrent_fault && power_stage_en);
	// cycles since a shutdown cause was last seen, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			quiet <= MIN_WAIT;
		else if (hot)
			quiet <= 0;
		else if (quiet < MIN_WAIT)
			quiet <= quiet + 1;
	end
	// length of the running status assertion, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			run <= 0;
		else if (!protection_status_out_oe)
			run <= 0;
		else if (run < MIN_WAIT)
			run <= run + 1;
	end
	// ------------------------------------
	// properties
	// ------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_short_blocks:
	assert property (output_short_supply [*8] |=> !$rose(power_stage_en))
		else $error("stage enabled during short");
	a_fault_off:
	assert property (lvl [*6] |-> !power_stage_en && protection_status_out_oe)
		else $error("stage on during shutdown fault");
	a_restart_wait:
	assert property ($rose(power_stage_en) |-> quiet >= MIN_WAIT)
		else $error("restart came too early");
	a_status_long:
	assert property ($fell(protection_status_out_oe) |->
		run == 1 || run >= MIN_WAIT) else $error("status pulse too short");
	a_warn_set:
	assert property ((junction_temp >= 8'h8B) [*6] |->
		thermal_warning_out_oe) else $error("warning missing");
	a_warn_clear:
	assert property ((junction_temp < 8'h8A) [*6] |->
		!thermal_warning_out_oe) else $error("warning stuck");
	a_fold_idle:
	assert property ((junction_temp <= 8'h91 || mode_level >= 7'h42) [*6]
		|-> thermal_gain_foldback == 3'h0) else $error("stray foldback");
	a_fold_full:
	assert property ((junction_temp == 8'h99 && mode_level >= 7'h2A
		&& mode_level <= 7'h37) [*6] |-> thermal_gain_foldback == 3'h6)
		else $error("foldback short of full");
	a_pins_low:
	assert property (!thermal_warning_out_o && !protection_status_out_o)
		else $error("diagnostic pin driven high");
	a_off_muted:
	assert property (!power_stage_en |-> mute_en && !switching_en)
		else $error("switching without power stage");
endmodule
bind aps_supervisor aps_props #(.MS_CYCLES(MS_CYCLES)) i_aps_props (
	.pclk, .presetn, .output_short_supply, .undervoltage_fault,
	.overvoltage_fault, .clock_loss_fault, .overcurrent_fault,
	.positive_analog_supply, .negative_analog_supply, .junction_temp,
	.mode_level, .power_stage_en, .switching_en, .mute_en,
	.thermal_gain_foldback, .thermal_warning_out_o, .thermal_warning_out_oe,
	.protection_status_out_o, .protection_status_out_oe
);
`default_nettype wire

/* File: tb/aps_analog_model.sv */
// supply comparators and diagnostic pull-ups around the supervisor
// assumes supply magnitudes in the unit of the supervisor inputs
`timescale 1ns/100ps
`default_nettype none
module aps_analog_model #(
	parameter int UV_SUM = 40,
	parameter int OV_SUM = 170
) (
	input  wire logic [7:0] sup_pos,
	input  wire logic [7:0] sup_neg,
	input  wire logic       clk_present,
	input  wire logic       warn_oe,
	input  wire logic       stat_oe,
	output logic            undervoltage_fault,
	output logic            overvoltage_fault,
	output logic            clock_loss_fault,
	output logic            warn_pin,
	output logic            stat_pin
);
	// ------------------------------------
	// comparators, no hysteresis
	// ------------------------------------
	int total;
	// limits act on the rail-to-rail span, like the real comparators
	assign total = int'(sup_pos) + int'(sup_neg);
	assign undervoltage_fault = total < UV_SUM;
	assign overvoltage_fault  = total > OV_SUM;
	assign clock_loss_fault   = !clk_present;
	// open drain: the pull-up wins whenever nobody pulls low
	assign warn_pin = !warn_oe;
	assign stat_pin = !stat_oe;
endmodule
`default_nettype wire

/* File: tb/aps_supervisor_bench.sv */
// self-checking bench for the protection supervisor
// assumes shortened counts: 10 cycles a ms, 4 a switching period
`timescale 1ns/100ps
`default_nettype none
module aps_supervisor_bench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        short_r, oc_r, lim_r, clk_ok, uv, ov, cl, e;
	logic        pse, swe, mte, wo, woe, so, soe, wpin, spin;
	logic [7:0]  paddr, sp, sn, temp;
	logic [6:0]  mode;
	logic [2:0]  fold;
	logic [31:0] pwdata, prdata, q;
	int          err_total, n_tests;

	aps_supervisor #(.MS_CYCLES(10), .SWITCH_CYCLES(4)) i_aps_supervisor (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .output_short_supply(short_r),
		.undervoltage_fault(uv), .overvoltage_fault(ov),
		.clock_loss_fault(cl), .overcurrent_fault(oc_r),
		.current_limit_active(lim_r), .positive_analog_supply(sp),
		.negative_analog_supply(sn), .junction_temp(temp),
		.mode_level(mode), .power_stage_en(pse), .switching_en(swe),
		.mute_en(mte), .thermal_gain_foldback(fold),
		.thermal_warning_out_o(wo), .thermal_warning_out_oe(woe),
		.protection_status_out_o(so), .protection_status_out_oe(soe));
	aps_analog_model i_aps_analog_model (
		.sup_pos(sp), .sup_neg(sn), .clk_present(clk_ok), .warn_oe(woe),
		.stat_oe(soe), .undervoltage_fault(uv), .overvoltage_fault(ov),
		.clock_loss_fault(cl), .warn_pin(wpin), .stat_pin(spin));

	// ------------------------------------
	// clock and helpers
	// ------------------------------------
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task automatic wcyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// bounded wait for the stage enable to reach v
	task automatic wait_pe(input logic v, input int n);
		while (pse !== v && n > 0) begin
			@(posedge pclk);
			n--;
		end
	endtask
	// request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input int d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// one cause at a time; off restores nominal supplies and clock
	task automatic set_fault(input int k, input logic on);
		sp <= (!on || k > 2) ? 8'h28 :
			k == 0 ? 8'h0A : k == 1 ? 8'h5A : 8'h3C;
		sn <= (!on || k > 2) ? 8'h28 :
			k == 0 ? 8'h0A : k == 1 ? 8'h5A : 8'h14;
		clk_ok <= !(on && k == 3);
		temp <= (on && k == 4) ? 8'h9A : 8'h19;
	endtask
	// ------------------------------------
	// scenarios
	// ------------------------------------
	task automatic t_start();
		wcyc(60);
		chk({pse, soe, spin}, 3'h2);
		short_r <= 1'b0;
		wait_pe(1'b1, 200);
		wcyc(20);
		chk({pse, swe, mte, soe}, 4'hD);
		wcyc(1200);
		chk({soe, spin}, 2'h1);
		$display("start-up test done");
	endtask
	task automatic t_thermal();
		logic [7:0] tv [7] = '{8'h8B, 8'h8A, 8'h89, 8'h99, 8'h95, 8'h96, 8'h19};
		logic [6:0] mv [7] = '{7'h32, 7'h32, 7'h32, 7'h32, 7'h32, 7'h46, 7'h32};
		logic [4:0] ev [7] = '{5'h08, 5'h08, 5'h18, 5'h0E, 5'h0B, 5'h08, 5'h18};
		for (int i = 0; i < 7; i++) begin
			temp <= tv[i];
			mode <= mv[i];
			wcyc(8);
			chk({wpin, pse, fold}, ev[i]);
		end
		$display("thermal test done");
	endtask
	task automatic t_mode();
		logic [6:0] mv [6] = '{7'h1E, 7'h0F, 7'h05, 7'h0F, 7'h46, 7'h32};
		logic [1:0] ev [6] = '{2'h3, 2'h3, 2'h1, 2'h1, 2'h2, 2'h2};
		for (int i = 0; i < 6; i++) begin
			mode <= mv[i];
			wcyc(30);
			chk({pse, mte}, ev[i]);
		end
		$display("mode test done");
	endtask
	task automatic t_regs();
		apb(1'b0, aps_pkg::REG_CTRL, 0);
		chk(q, aps_pkg::CTRL_RESET);
		apb(1'b0, 8'h0C, 0);
		chk({e, q[30:0]}, 32'h8000_0000);
		apb(1'b1, aps_pkg::REG_STATUS, -1);
		chk(e, 1'b0);
		apb(1'b1, aps_pkg::REG_CTRL, 1);
		wcyc(10);
		apb(1'b0, aps_pkg::REG_STATUS, 0);
		chk({pse, q[2:0]}, 4'h0);
		apb(1'b0, aps_pkg::REG_TEMP, 0);
		chk(q[10:0], 11'h019);
		apb(1'b1, aps_pkg::REG_CTRL, 0);
		wait_pe(1'b1, 100);
		chk(pse, 1'b1);
		$display("register test done");
	endtask
	task automatic t_faults();
		for (int k = 0; k < 5; k++) begin
			set_fault(k, 1'b1);
			wcyc(10);
			chk({pse, soe, woe}, {2'h1, 1'(k == 4)});
			set_fault(k, 1'b0);
			wcyc(500);
			set_fault(3, 1'b1);
			wcyc(20);
			set_fault(3, 1'b0);
			wcyc(900);
			chk(pse, 1'b0);
			wait_pe(1'b1, 300);
			chk(pse, 1'b1);
			wcyc(1100);
		end
		$display("fault test done");
	endtask
	task automatic t_ocp();
		int  n;
		logic last;
		n = 0;
		lim_r <= 1'b1;
		repeat (40) begin
			@(posedge pclk);
			n += (soe === 1'b1);
		end
		lim_r <= 1'b0;
		chk({pse, 1'(n >= 9 && n <= 11)}, 2'h3);
		oc_r <= 1'b1;
		short_r <= 1'b1;
		wcyc(10);
		oc_r <= 1'b0;
		wcyc(2500);
		chk({pse, soe}, 2'h1);
		short_r <= 1'b0;
		wait_pe(1'b1, 300);
		wcyc(1100);
		n = 0;
		last = 1'b1;
		oc_r <= 1'b1;
		repeat (2600) begin
			@(posedge pclk);
			n += (pse === 1'b1 && !last);
			last = pse;
		end
		chk(n, 2);
		oc_r <= 1'b0;
		wait_pe(1'b1, 1200);
		chk(pse, 1'b1);
		$display("overcurrent test done");
	endtask
	// ------------------------------------
	// sequence and verdict
	// ------------------------------------
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		{presetn, psel, penable, pwrite, oc_r, lim_r} = 6'h00;
		{short_r, clk_ok, paddr, pwdata} = {2'h3, 40'h0};
		{sp, sn, temp, mode} = {8'h28, 8'h28, 8'h19, 7'h32};
		err_total = 0;
		n_tests = 0;
		wcyc(3);
		presetn <= 1'b1;
		t_start();
		t_thermal();
		t_mode();
		t_regs();
		t_faults();
		t_ocp();
		end_of_test();
	end
	// the tests take about 21500 cycles
	initial begin
		wcyc(60000);
		err_total++;
		end_of_test();
	end
endmodule
`default_nettype wire
